// ### sdadc_ctrl.sv
// Setup word, result word with holding buffer and serial access of a sigma-delta converter
//
// What this block does
// - Result word is read only to host
// - Bit 23 picks two's complement or offset
// - Unipolar results are straight binary always
// - Bits 22..12 set word period 512*code, codes below 10 run as 10
// - Results settle within three to four words
// - Bits 11..9 mode, reset to self calibration
// - Bit 8 bipolar, set on reset
// - Gain field: amplifier gain plus digital multiply
// - Bit 4 enables open input current
// - Standby halts filter, ready high, modulator off
// - Leaving standby restarts, calibrating first if asked
// - Bit 2 ascending or descending byte order
// - Bit 1 picks LSB or MSB first
// - Bit 0 moves read data to output line
// - Ready goes low when new result present
// - Result under read stays, ready stays low
// - One result holding buffer behind result word
// - Late finish drops next, keeps following result
// - Read done releases ready, buffer moves in
// - Writes to bytes 2 or 1 restart
// - Byte 0 write leaves ready alone unless it enters or leaves standby
// - Two select bits plus starting byte
// - Shift out on falling, sample on rising
`timescale 1ns/100ps
`include "sdadc_regs.svh"
`default_nettype none

module sdadc_ctrl
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        sdio_i,
   output logic             sdio_o,
   output logic             sdio_oe_o,
   output logic             sdo_o,
   output logic             sdo_oe_o,
   input  wire logic [23:0] conv_data_i,
   output logic             result_ready_n_o,
   output logic [2:0]       operating_mode_o,
   output logic [1:0]       pga_gain_log2_o,
   output logic [2:0]       digital_shift_o,
   output logic             open_input_current_enable_o,
   output logic             modulator_clk_en_o,
   output logic             filter_run_o,
   output logic             calibrate_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Next starting byte, wrapping inside the three bytes
   function automatic logic [1:0] sdadc_step(input logic [1:0] b, input logic up);
      begin
         if (up)
            return (b == `SDADC_BYTE_LAST) ? 2'h0 : 2'(b + 2'h1);
         else
            return (b == 2'h0) ? `SDADC_BYTE_LAST : 2'(b - 2'h1);
      end
   endfunction

   // Only self calibration is known here; other codes are opaque
   function automatic logic sdadc_is_cal(input logic [2:0] m);
      begin
         return m == `SDADC_MODE_SELF_CAL;
      end
   endfunction

   // Digital multiply with saturation, then output coding
   function automatic logic [23:0] sdadc_code(input logic [23:0] raw,
                                              input logic        bip,
                                              input logic        dc,
                                              input logic [2:0]  sh);
      logic [27:0] w;
      logic [23:0] v;
      begin
         w = 28'h0;
         v = 24'h0;
         if (bip)
         begin
            w = {{5{~raw[23]}}, raw[22:0]} << sh;
            if (w[27:23] != {5{w[27]}})
               v = w[27] ? 24'h800000 : 24'h7fffff;
            else
               v = w[23:0];
            v = dc ? v : {~v[23], v[22:0]};
         end
         else
         begin
            w = {4'h0, raw} << sh;
            v = (w[27:24] != 4'h0) ? 24'hffffff : w[23:0];
         end
         return v;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Shared state

   sdadc_pkg::sdadc_setup_t  setup_reg;
   logic [23:0]              result_reg;
   sdadc_pkg::sdadc_lstate_t lstate_reg;
   logic [2:0]               bit_reg;
   logic [7:0]               sh_reg;
   logic [7:0]               instr_reg;
   logic [1:0]               byte_reg;
   logic [1:0]               left_reg;
   logic [7:0]               wbyte_reg;
   logic [1:0]               widx_reg;
   logic                     wtog_reg;
   logic                     rtog_reg;
   logic                     dout_reg;
   logic                     sdio_oe_reg;
   logic                     sdo_oe_reg;
   logic                     lrst_n;
   logic [7:0]               sh_next;
   logic [2:0]               bidx;
   logic [23:0]              rd_word;
   logic                     sel_setup;
   logic                     sel_result;

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain on the host serial clock

   // Frame end clears the link side, since the clock stops outside frames
   assign lrst_n = rst_n_i & ~cs_n_i;

   // Setup bits seen here only change between bytes, so they are quasi-static
   assign sh_next = setup_reg.lsb_first ? {sdio_i, sh_reg[7:1]}
                                        : {sh_reg[6:0], sdio_i};
   assign sel_result = instr_reg[`SDADC_INS_SEL_HI:`SDADC_INS_SEL_LO] == `SDADC_SEL_RESULT;
   assign sel_setup  = instr_reg[`SDADC_INS_SEL_HI:`SDADC_INS_SEL_LO] == `SDADC_SEL_SETUP;

   // Sample on the rising edge and walk through the frame
   always_ff @(posedge sclk_i or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         lstate_reg <= sdadc_pkg::SDADC_L_INSTR;
         bit_reg    <= 3'h0;
         sh_reg     <= 8'h00;
         instr_reg  <= 8'h00;
         byte_reg   <= 2'h0;
         left_reg   <= 2'h0;
      end
      else
      begin
         bit_reg <= 3'(bit_reg + 3'h1);
         sh_reg  <= sh_next;
         if (bit_reg == 3'h7)
         begin
            case (lstate_reg)
               sdadc_pkg::SDADC_L_INSTR:
               begin
                  instr_reg  <= sh_next;
                  byte_reg   <= sh_next[1:0];
                  left_reg   <= sh_next[`SDADC_INS_CNT_HI:`SDADC_INS_CNT_LO];
                  lstate_reg <= sh_next[`SDADC_INS_RW_BIT] ? sdadc_pkg::SDADC_L_WRITE
                                                           : sdadc_pkg::SDADC_L_READ;
               end
               sdadc_pkg::SDADC_L_WRITE,
               sdadc_pkg::SDADC_L_READ:
               begin
                  byte_reg <= sdadc_step(byte_reg, setup_reg.byte_order_select);
                  left_reg <= 2'(left_reg - 2'h1);
                  if (left_reg == 2'h0)
                     lstate_reg <= sdadc_pkg::SDADC_L_DONE;
               end
               default:
                  lstate_reg <= sdadc_pkg::SDADC_L_DONE;
            endcase
         end
      end
   end

   // Completed write bytes and finished result reads leave as toggles
   always_ff @(posedge sclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wbyte_reg <= 8'h00;
         widx_reg  <= 2'h0;
         wtog_reg  <= 1'b0;
         rtog_reg  <= 1'b0;
      end
      else if (!cs_n_i && bit_reg == 3'h7)
      begin
         // Result word and the unused selects are never written
         if (lstate_reg == sdadc_pkg::SDADC_L_WRITE && sel_setup)
         begin
            wbyte_reg <= sh_next;
            widx_reg  <= byte_reg;
            wtog_reg  <= ~wtog_reg;
         end
         if (lstate_reg == sdadc_pkg::SDADC_L_READ && sel_result && left_reg == 2'h0)
            rtog_reg <= ~rtog_reg;
      end
   end

   // Read data word, other selects read as zero
   assign rd_word = sel_result ? result_reg : (sel_setup ? setup_reg : 24'h000000);
   assign bidx    = setup_reg.lsb_first ? bit_reg : 3'(3'h7 - bit_reg);

   // Drive out on the falling edge, onto the line the setup word picks
   always_ff @(negedge sclk_i or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         dout_reg    <= 1'b0;
         sdio_oe_reg <= 1'b0;
         sdo_oe_reg  <= 1'b0;
      end
      else
      begin
         dout_reg    <= rd_word[{byte_reg, bidx}];
         sdio_oe_reg <= (lstate_reg == sdadc_pkg::SDADC_L_READ) & ~setup_reg.serial_line_select;
         sdo_oe_reg  <= (lstate_reg == sdadc_pkg::SDADC_L_READ) & setup_reg.serial_line_select;
      end
   end

   assign sdio_o    = dout_reg;
   assign sdo_o     = dout_reg;
   assign sdio_oe_o = sdio_oe_reg;
   assign sdo_oe_o  = sdo_oe_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Crossing into the oscillator domain

   sdadc_pkg::sdadc_xing_t x1_reg;
   sdadc_pkg::sdadc_xing_t x2_reg;
   sdadc_pkg::sdadc_xing_t x3_reg;
   logic                   frame;
   logic                   wr_ev;
   logic                   rd_ev;

   // Two stages per signal; the third only feeds edge detection
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         x1_reg <= '{cs_n: 1'b1, wr_tog: 1'b0, rd_tog: 1'b0};
         x2_reg <= '{cs_n: 1'b1, wr_tog: 1'b0, rd_tog: 1'b0};
         x3_reg <= '{cs_n: 1'b1, wr_tog: 1'b0, rd_tog: 1'b0};
      end
      else if (ce_i)
      begin
         x1_reg <= '{cs_n: cs_n_i, wr_tog: wtog_reg, rd_tog: rtog_reg};
         x2_reg <= x1_reg;
         x3_reg <= x2_reg;
      end
   end

   assign frame = ~x2_reg.cs_n;
   assign wr_ev = ce_i & (x2_reg.wr_tog ^ x3_reg.wr_tog);
   assign rd_ev = ce_i & (x2_reg.rd_tog ^ x3_reg.rd_tog);

   ////////////////////////////////////////////////////////////////////////////////
   // Setup word and sequencing

   sdadc_pkg::sdadc_setup_t wr_word;
   logic                    restart;
   logic [10:0]             code_eff;
   logic [19:0]             period_last;
   logic [19:0]             period_reg;
   logic                    calib_reg;
   logic [2:0]              cal_cnt_reg;
   logic [1:0]              settle_reg;
   logic                    tick;
   logic                    new_word;

   // Byte merge of a host write
   always_comb
   begin
      wr_word = setup_reg;
      case (widx_reg)
         2'h0:    wr_word[7:0]   = wbyte_reg;
         2'h1:    wr_word[15:8]  = wbyte_reg;
         default: wr_word[23:16] = wbyte_reg;
      endcase
   end

   // Upper byte writes and leaving standby restart the converter
   assign restart = wr_ev & ((widx_reg != 2'h0)
                  | (setup_reg.standby_enable & ~wr_word.standby_enable));

   // Setup word, reset defaults from the header
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         setup_reg <= `SDADC_SETUP_RST;
      else if (wr_ev)
         setup_reg <= wr_word;
   end

   // Codes below the legal floor run at the floor
   assign code_eff    = (setup_reg.decimation_code < `SDADC_DECIM_MIN) ? `SDADC_DECIM_MIN
                                                                      : setup_reg.decimation_code;
   assign period_last = 20'({code_eff, {`SDADC_NOTCH_LOG2{1'b0}}} - 20'h1);
   assign tick        = ce_i & ~setup_reg.standby_enable & (period_reg == period_last);

   // Word period counter, frozen in standby
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         period_reg <= 20'h0;
      else if (ce_i)
      begin
         if (restart || tick)
            period_reg <= 20'h0;
         else if (!setup_reg.standby_enable)
            period_reg <= 20'(period_reg + 20'h1);
      end
   end

   // Calibration first, then settling words are dropped before delivery
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         calib_reg   <= 1'b1;
         cal_cnt_reg <= `SDADC_CAL_WORDS;
         settle_reg  <= `SDADC_SETTLE_WORDS;
      end
      else if (ce_i)
      begin
         if (restart)
         begin
            calib_reg   <= sdadc_is_cal(wr_word.operating_mode_field);
            cal_cnt_reg <= `SDADC_CAL_WORDS;
            settle_reg  <= `SDADC_SETTLE_WORDS;
         end
         else if (tick)
         begin
            if (calib_reg)
            begin
               cal_cnt_reg <= 3'(cal_cnt_reg - 3'h1);
               if (cal_cnt_reg == 3'h1)
                  calib_reg <= 1'b0;
            end
            else if (settle_reg != 2'h0)
               settle_reg <= 2'(settle_reg - 2'h1);
         end
      end
   end

   assign new_word = tick & ~calib_reg & (settle_reg == 2'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // Result word, holding buffer and ready line

   logic [23:0] coded;
   logic [23:0] hold_reg;
   logic        full_reg;
   logic        unread_reg;
   logic [4:0]  high_reg;
   logic        ready_n_reg;
   logic [23:0] result_next;
   logic [23:0] hold_next;
   logic        full_next;
   logic        unread_next;
   logic        arm;
   logic [2:0]  dshift;

   assign dshift = setup_reg.gain_field[2] ? 3'({1'b0, setup_reg.gain_field[1:0]} + 3'h1)
                                           : 3'h0;
   assign coded  = sdadc_code(conv_data_i, setup_reg.bipolar, setup_reg.coding_select, dshift);

   // Read completion first, then the arriving word, restart last
   always_comb
   begin
      result_next = result_reg;
      hold_next   = hold_reg;
      full_next   = full_reg;
      unread_next = unread_reg;
      arm         = 1'b0;
      if (rd_ev)
         unread_next = 1'b0;
      // A buffered word moves up once nobody is reading
      if (!unread_next && full_next && (rd_ev || !frame))
      begin
         result_next = hold_next;
         full_next   = 1'b0;
         unread_next = 1'b1;
         arm         = 1'b1;
      end
      if (new_word)
      begin
         if (!unread_next && !frame)
         begin
            result_next = coded;
            unread_next = 1'b1;
            arm         = 1'b1;
         end
         else if (!full_next)
         begin
            hold_next = coded;
            full_next = 1'b1;
         end
         else if (!frame)
         begin
            result_next = hold_next;
            hold_next   = coded;
         end
         else
            hold_next = coded;
      end
      // Restart and standby force the line high and flush pending words
      if (restart || setup_reg.standby_enable)
      begin
         unread_next = 1'b0;
         full_next   = 1'b0;
      end
   end

   // Result storage; the host has no write path into it
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         result_reg <= 24'h000000;
         hold_reg   <= 24'h000000;
         full_reg   <= 1'b0;
         unread_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         result_reg <= result_next;
         hold_reg   <= hold_next;
         full_reg   <= full_next;
         unread_reg <= unread_next;
      end
   end

   // Ready low only after the minimum high time since the last release
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         high_reg    <= 5'(`SDADC_MIN_HIGH_CYC);
         ready_n_reg <= 1'b1;
      end
      else if (ce_i)
      begin
         if (arm || !unread_next)
            high_reg <= 5'(`SDADC_MIN_HIGH_CYC);
         else if (high_reg != 5'h0)
            high_reg <= 5'(high_reg - 5'h1);
         ready_n_reg <= ~(unread_next & ~arm & (high_reg == 5'h0));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Analog and filter controls

   // Registered so the analog side sees clean levels
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         operating_mode_o            <= 3'h0;
         pga_gain_log2_o             <= 2'h0;
         digital_shift_o             <= 3'h0;
         open_input_current_enable_o <= 1'b0;
         modulator_clk_en_o          <= 1'b0;
         filter_run_o                <= 1'b0;
         calibrate_o                 <= 1'b0;
      end
      else if (ce_i)
      begin
         operating_mode_o            <= setup_reg.operating_mode_field;
         pga_gain_log2_o             <= setup_reg.gain_field[2] ? 2'h3
                                                                : setup_reg.gain_field[1:0];
         digital_shift_o             <= dshift;
         open_input_current_enable_o <= setup_reg.open_input_current_enable;
         modulator_clk_en_o          <= ~setup_reg.standby_enable;
         filter_run_o                <= ~setup_reg.standby_enable;
         calibrate_o                 <= calib_reg & ~setup_reg.standby_enable;
      end
   end

   assign result_ready_n_o = ready_n_reg;

endmodule

`default_nettype wire

// ### sdadc_regs.svh
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef SDADC_REGS_SVH
`define SDADC_REGS_SVH

// Register select codes and instruction byte fields
`define SDADC_SEL_RESULT      2'h0
`define SDADC_SEL_SETUP       2'h1
`define SDADC_INS_RW_BIT      7
`define SDADC_INS_CNT_HI      6
`define SDADC_INS_CNT_LO      5
`define SDADC_INS_SEL_HI      3
`define SDADC_INS_SEL_LO      2
`define SDADC_BYTE_LAST       2'h2

// Setup word reset value and field codes
`define SDADC_SETUP_RST       24'h00a100
`define SDADC_MODE_SELF_CAL   3'h0
`define SDADC_DECIM_MIN       11'h00a
`define SDADC_NOTCH_LOG2      9

// Sequencing counts in output word periods
`define SDADC_CAL_WORDS       3'h4
`define SDADC_SETTLE_WORDS    2'h3

// Minimum high time of the ready line
`define SDADC_CLK_PERIOD_NS   4
`define SDADC_MIN_HIGH_NS     100
`define SDADC_MIN_HIGH_CYC    ((`SDADC_MIN_HIGH_NS + `SDADC_CLK_PERIOD_NS - 1) / `SDADC_CLK_PERIOD_NS)

`endif

// ### sdadc_pkg.sv
// Types shared by the converter control block
`default_nettype none
package sdadc_pkg;

   // Setup word layout, bit 23 down to bit 0
   typedef struct packed {
      logic        coding_select;
      logic [10:0] decimation_code;
      logic [2:0]  operating_mode_field;
      logic        bipolar;
      logic [2:0]  gain_field;
      logic        open_input_current_enable;
      logic        standby_enable;
      logic        byte_order_select;
      logic        lsb_first;
      logic        serial_line_select;
   } sdadc_setup_t;

   // Serial frame phases
   typedef enum logic [1:0] {
      SDADC_L_INSTR = 2'b00,
      SDADC_L_WRITE = 2'b01,
      SDADC_L_READ  = 2'b10,
      SDADC_L_DONE  = 2'b11
   } sdadc_lstate_t;

   // Levels and toggles crossing into the oscillator domain
   typedef struct packed {
      logic cs_n;
      logic wr_tog;
      logic rd_tog;
   } sdadc_xing_t;

endpackage
`default_nettype wire

// ### sdadc_ctrl_asserts.sv
// Checker of the converter control block ports
`timescale 1ns/100ps
`include "sdadc_regs.svh"
`default_nettype none
module sdadc_ctrl_asserts
(
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic       sclk_i,
   input wire logic       sdio_o,
   input wire logic       sdio_oe_o,
   input wire logic       sdo_oe_o,
   input wire logic       result_ready_n_o,
   input wire logic [2:0] operating_mode_o,
   input wire logic [1:0] pga_gain_log2_o,
   input wire logic [2:0] digital_shift_o,
   input wire logic       open_input_current_enable_o,
   input wire logic       modulator_clk_en_o,
   input wire logic       filter_run_o,
   input wire logic       calibrate_o
);
   localparam int MINH = `SDADC_MIN_HIGH_CYC;
   logic [7:0] hi_cnt_reg;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////
   // Cycles the ready line has stood high, saturating
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i) hi_cnt_reg <= 8'h00;
      else if (!result_ready_n_o) hi_cnt_reg <= 8'h00;
      else if (hi_cnt_reg != 8'hff) hi_cnt_reg <= hi_cnt_reg + 8'h01;
   ////////////////////////////////////////////////////////////
   // Standby, line use, serial edges, ready timing, gain, reset and calibration
   property p_stby; !filter_run_o |-> result_ready_n_o; endproperty
   a_stby: assert property (p_stby) else $error("ready low in standby");
   property p_mclk; modulator_clk_en_o == filter_run_o; endproperty
   a_mclk: assert property (p_mclk) else $error("modulator and filter differ");
   property p_line; !(sdio_oe_o && sdo_oe_o); endproperty
   a_line: assert property (p_line) else $error("both read lines driven");
   property p_edge; $rose(sdio_oe_o || sdo_oe_o) |-> !sclk_i; endproperty
   a_edge: assert property (p_edge) else $error("drive began with clock high");
   property p_hold; sclk_i && $past(sclk_i) && sdio_oe_o |-> $stable(sdio_o); endproperty
   a_hold: assert property (p_hold) else $error("read bit moved while clock high");
   property p_minhi; $fell(result_ready_n_o) |-> hi_cnt_reg >= MINH; endproperty
   a_minhi: assert property (p_minhi) else $error("ready high time too short");
   property p_gain; pga_gain_log2_o != 2'h3 |-> digital_shift_o == 3'h0; endproperty
   a_gain: assert property (p_gain) else $error("multiply without gain 8");
   property p_rst;
      $rose(rst_n_i) |=> operating_mode_o == 3'h0 && calibrate_o
         && pga_gain_log2_o == 2'h0 && !open_input_current_enable_o;
   endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_cal; calibrate_o |-> result_ready_n_o; endproperty
   a_cal: assert property (p_cal) else $error("ready low in calibration");
   property p_mode; operating_mode_o != 3'h0 |=> !calibrate_o; endproperty
   a_mode: assert property (p_mode) else $error("calibrating in other mode");
   c_rdy: cover property ($fell(result_ready_n_o));
   c_sdo: cover property ($rose(sdo_oe_o));
   c_stby: cover property ($fell(filter_run_o));
endmodule
bind sdadc_ctrl sdadc_ctrl_asserts i_sdadc_ctrl_asserts (.clk_i, .rst_n_i, .sclk_i,
   .sdio_o, .sdio_oe_o, .sdo_oe_o, .result_ready_n_o, .operating_mode_o,
   .pga_gain_log2_o, .digital_shift_o, .open_input_current_enable_o,
   .modulator_clk_en_o, .filter_run_o, .calibrate_o);
`default_nettype wire

// ### sdadc_host.sv
// Serial host model that frames instructions and data
`timescale 1ns/100ps
`default_nettype none
module sdadc_host
(
   input  wire logic sdio_o_i,
   input  wire logic sdio_oe_i,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      line_o
);
   logic drv_en;
   logic drv_d;
   // No pull on the data line, so a released line shows the inverse
   assign line_o = sdio_oe_i ? sdio_o_i : (drv_en ? drv_d : ~drv_d);
   initial
   begin
      sclk_o = 1'b1; // Clock stands still high between frames
      cs_n_o = 1'b1;
      drv_en = 1'b0;
      drv_d  = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   // One frame: instruction byte, then nb bytes written or read
   task automatic xfer(input logic [7:0] ins, input logic [23:0] wd, input logic lf,
                       input logic sl, output logic [23:0] rd, output logic oe_ok);
      int          nb;
      int          i;
      logic [31:0] frm;
      nb = ins[6:5] + 1;
      frm = {wd, ins};
      rd = 24'h0;
      oe_ok = 1'b1;
      cs_n_o = 1'b0;
      #20;
      for (int k = 0; k < 8 * (nb + 1); k++)
      begin
         i = lf ? k % 8 : 7 - k % 8;
         sclk_o = 1'b0;
         drv_en = (k < 8) || ins[7];
         drv_d = frm[(k / 8) * 8 + i];
         #62.5;
         sclk_o = 1'b1;
         if (k >= 8 && !ins[7])
         begin
            rd[(k / 8 - 1) * 8 + i] = sl ? sdo_i : line_o;
            oe_ok &= sl ? (sdo_oe_i && !sdio_oe_i) : (sdio_oe_i && !sdo_oe_i);
         end
         #62.5;
      end
      drv_en = 1'b0;
      #20 cs_n_o = 1'b1; // Frames are read at once, well inside the buffer limits
      #200;
   endtask
endmodule
`default_nettype wire

// ### sdadc_ctrl_tb_top.sv
// Testbench of the converter control block
`timescale 1ns/100ps
`default_nettype none
module sdadc_ctrl_tb_top;
   logic        clk_i, rst_n_i, sclk, cs_n, line, sd_o, sd_oe, so, so_oe, rdy_n;
   logic        oce, mce, frun, cal, oe_ok;
   logic [2:0]  mode, shift;
   logic [1:0]  gain;
   logic [23:0] conv, rd;
   int          errors, n_compared, cyc;
   sdadc_ctrl i_sdadc_ctrl (.clk_i, .rst_n_i, .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
      .sdio_i(line), .sdio_o(sd_o), .sdio_oe_o(sd_oe), .sdo_o(so), .sdo_oe_o(so_oe),
      .conv_data_i(conv), .result_ready_n_o(rdy_n), .operating_mode_o(mode),
      .pga_gain_log2_o(gain), .digital_shift_o(shift), .open_input_current_enable_o(oce),
      .modulator_clk_en_o(mce), .filter_run_o(frun), .calibrate_o(cal));
   sdadc_host i_sdadc_host (.sdio_o_i(sd_o), .sdio_oe_i(sd_oe), .sdo_i(so),
      .sdo_oe_i(so_oe), .sclk_o(sclk), .cs_n_o(cs_n), .line_o(line));
   ////////////////////////////////////////////////////////////
   function automatic logic [23:0] outs();
      return {12'h0, mode, gain, shift, oce, mce, frun, cal};
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic io(input logic [7:0] ins, input logic [23:0] wd,
                     input logic lf = 1'b0, input logic sl = 1'b0);
      i_sdadc_host.xfer(ins, wd, lf, sl, rd, oe_ok);
      @(posedge clk_i);
      #1;
   endtask
   // Bounded wait for a new result
   task automatic wait_rdy(input int lim);
      for (int i = 0; i < lim && rdy_n !== 1'b0; i++)
         @(posedge clk_i);
      #1;
      chk({23'h0, rdy_n}, 24'h0, "ready low");
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Ceiling a little above the longest expected run
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 105000)
      begin
         errors++;
         $display("BAD %0t run did not finish", $time);
         final_report();
      end
   end
   initial
   begin
      rst_n_i = 1'b0;
      conv = 24'h812345;
      repeat (12) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      #1000;
      io(8'h46, 24'h0);
      chk(rd, 24'h00a100, "setup reset");
      chk(outs(), 24'h000007, "outputs reset");
      $display("end of test: reset values");
      wait_rdy(45000);
      io(8'h42, 24'h0);
      chk(rd, 24'h452381, "offset binary");
      chk({23'h0, oe_ok}, 24'h1, "two wire read");
      chk({23'h0, rdy_n}, 24'h1, "ready released");
      io(8'h82, 24'h0000ff);
      io(8'h42, 24'h0);
      chk(rd, 24'h452381, "result read only");
      $display("end of test: result word");
      // Every gain code with the open input current following bit 0 of the code
      for (int g = 0; g < 8; g++)
      begin
         io(8'h84, {16'h0, 3'(g), g[0], 4'h0});
         chk(outs(), {12'h0, 3'h0, g < 4 ? 2'(g) : 2'h3, g < 4 ? 3'h0 : 3'(g - 3),
             g[0], 3'b110}, "gain");
      end
      chk({23'h0, rdy_n}, 24'h0, "ready kept");
      $display("end of test: gain");
      io(8'h84, 24'h000007);
      // The result word was taken mid gain sweep, so framing is checked on the setup word
      io(8'h44, 24'h0, 1'b1, 1'b1);
      chk(rd, 24'h00a107, "ascending lsb first");
      chk({23'h0, oe_ok}, 24'h1, "three wire read");
      io(8'h84, 24'h0, 1'b1);
      $display("end of test: framing");
      io(8'hc6, 24'h00a380);
      chk(outs(), 24'h000206, "mode one");
      chk({23'h0, rdy_n}, 24'h1, "restart ready");
      wait_rdy(22000);
      io(8'h42, 24'h0);
      chk(rd, 24'h452301, "twos complement");
      wait_rdy(6000);
      io(8'h85, 24'h0000a2);
      chk({23'h0, rdy_n}, 24'h1, "byte one restart");
      wait_rdy(22000);
      io(8'h42, 24'h0);
      chk(rd, 24'h452381, "unipolar straight");
      $display("end of test: coding");
      io(8'h84, 24'h000008);
      chk(outs(), 24'h000200, "standby");
      chk({23'h0, rdy_n}, 24'h1, "standby ready");
      $display("end of test: standby");
      final_report();
   end
endmodule
`default_nettype wire
